// *** src/emsr_record.sv ***
// software error record 0: status, miscellaneous and address registers
`timescale 1ns/100ps
`include "emsr_defines.svh"

// Functional notes
// RULE_01: bit 41 flags that the error count under-reports.
// RULE_02: bit 40 is a sticky counter overflow flag.
// RULE_03: overflow with corrected-fault interrupt enabled raises the fault line.
// RULE_04: count increments per corrected error and per differing-syndrome error.
// RULE_05: the error count field is present in this record.
// RULE_06: bits 31:0 hold error data chosen by record and syndrome.
// RULE_07: data word packs from bit 0; unused bits read zero.
// RULE_08: illegal port access packs read flag, sparse, size, length.
// RULE_09: powered-down unit access packs unit 24:16 and core 8:0.
// RULE_10: rejected power down packs unit and core like the above.
// RULE_11: rejected property or pending base change packs core 8:0.
// RULE_12: abandoned wake control change packs core 8:0.
// RULE_13: failed controller sleep request packs the offending core.
// RULE_14: core asleep with groups enabled packs that core.
// RULE_15: soft interrupt with no target packs sending core, code 0xE.
// RULE_16: corrupted soft interrupt packs the core number.
// RULE_17: corrupted register reads fill the address register, code 0x6.
// RULE_18: read from powered-off translator fills the address register.
// RULE_19: missing shared interrupt block packs block number 4:0.
// RULE_20: out-of-range shared interrupt set or clear packs id 9:0.
// RULE_21: shared interrupt without legal target packs id 9:0.
// RULE_22: status bits 15:8 hold the syndrome that selects the encoding.
// RULE_23: count wraps to zero and sets overflow at the same moment.
module emsr_record (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire emsr_pkg::emsr_addr_t reg_addr_i,
  input  wire emsr_pkg::emsr_word_t reg_wdata_i,
  input  wire logic                 reg_wr_i,
  input  wire logic                 reg_rd_i,
  output emsr_pkg::emsr_word_t      reg_rdata_o,
  input  wire logic                 ce_i,
  input  wire logic                 err_valid_i,
  input  wire emsr_pkg::emsr_code_t err_syndrome_i,
  input  wire emsr_pkg::emsr_core_t err_core_i,
  input  wire emsr_pkg::emsr_core_t err_unit_i,
  input  wire logic                 err_rnw_i,
  input  wire logic                 err_sparse_i,
  input  wire logic [2:0]           err_size_i,
  input  wire logic [7:0]           err_len_i,
  input  wire logic [4:0]           err_block_i,
  input  wire logic [9:0]           err_irq_id_i,
  input  wire emsr_pkg::emsr_paddr_t err_paddr_i,
  input  wire logic                 err_ns_i,
  output logic                      fault_irq_o,
  output logic                      record_valid_o
);
  import emsr_pkg::*;

  // ************************************
  // state
  // ************************************
  logic        valid;
  logic        rec_ovf;
  emsr_code_t  syndrome;
  emsr_code_t  primary;
  emsr_word_t  misc_data;
  emsr_code_t  count;
  logic        cnt_ovf;
  logic        round_err;
  emsr_paddr_t paddr;
  logic        addr_ns;
  logic        cf_irq_en;

  emsr_word_t  enc_data;
  emsr_code_t  enc_primary;
  logic        enc_addr_used;

  logic        wr_status;
  logic        wr_misc_hi;
  logic        wr_ctrl;
  logic        capture;
  logic        inc_ue;
  logic        inc_any;
  emsr_code_t  base_count;
  emsr_code_t  next_count;
  logic        wrap;
  logic [63:0] misc_word;
  logic [63:0] addr_word;
  emsr_word_t  status_word;
  emsr_word_t  next_rdata;

  // ************************************
  // data word encoder
  // ************************************
  emsr_data_encoder u_encoder (
    .syndrome_i  (err_syndrome_i),
    .core_i      (err_core_i),
    .unit_i      (err_unit_i),
    .rnw_i       (err_rnw_i),
    .sparse_i    (err_sparse_i),
    .size_i      (err_size_i),
    .len_i       (err_len_i),
    .block_i     (err_block_i),
    .irq_id_i    (err_irq_id_i),
    .data_o      (enc_data),
    .primary_o   (enc_primary),
    .addr_used_o (enc_addr_used)
  );

  // ************************************
  // write decode
  // ************************************
  always_comb begin
    wr_status  = 1'b0;
    wr_misc_hi = 1'b0;
    wr_ctrl    = 1'b0;
    if (reg_wr_i && reg_addr_i == `EMSR_OFF_STATUS) begin
      wr_status = 1'b1;
    end else if (reg_wr_i && reg_addr_i == `EMSR_OFF_MISC_HI) begin
      wr_misc_hi = 1'b1;
    end else if (reg_wr_i && reg_addr_i == `EMSR_OFF_CTRL) begin
      wr_ctrl = 1'b1;
    end
  end

  // ************************************
  // event qualification
  // ************************************
  assign capture = err_valid_i && !valid;
  // a repeat of the recorded syndrome is not counted again
  assign inc_ue  = err_valid_i && valid && (err_syndrome_i != syndrome); // RULE_04
  assign inc_any = ce_i || inc_ue; // RULE_04

  // ************************************
  // error counter
  // ************************************
  always_comb begin
    base_count = wr_misc_hi ? reg_wdata_i[7:0] : count;
    wrap       = inc_any && (base_count == `EMSR_CNT_MAX); // RULE_23
    next_count = inc_any ? base_count + 8'h01 : base_count; // RULE_23
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count <= `EMSR_RST_COUNT;
    end else begin
      count <= next_count; // RULE_05
    end
  end

  // overflow is cleared only by writing one; a new wrap wins
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ovf <= 1'b0;
    end else begin
      cnt_ovf <= (cnt_ovf && !(wr_misc_hi && reg_wdata_i[8])) || wrap; // RULE_02
    end
  end

  // two counted events in one cycle add only one
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      round_err <= 1'b0;
    end else begin
      round_err <= (round_err && !(wr_misc_hi && reg_wdata_i[9]))
                   || (ce_i && inc_ue); // RULE_01
    end
  end

  // ************************************
  // fault interrupt
  // ************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cf_irq_en <= 1'b0;
    end else if (wr_ctrl) begin
      cf_irq_en <= reg_wdata_i[`EMSR_CTRL_CF_IRQ_EN];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fault_irq_o <= 1'b0;
    end else begin
      fault_irq_o <= cnt_ovf && cf_irq_en; // RULE_03
    end
  end

  // ************************************
  // status: valid and record overflow
  // ************************************
  // a new capture wins over a software clear in the same cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      valid <= 1'b0;
    end else begin
      valid <= (valid && !(wr_status && reg_wdata_i[`EMSR_ST_VALID]))
               || capture;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rec_ovf <= 1'b0;
    end else begin
      rec_ovf <= (rec_ovf && !(wr_status && reg_wdata_i[`EMSR_ST_REC_OVF]))
                 || (err_valid_i && valid);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      record_valid_o <= 1'b0;
    end else begin
      record_valid_o <= (valid && !(wr_status && reg_wdata_i[`EMSR_ST_VALID]))
                        || capture;
    end
  end

  // ************************************
  // status: syndrome and primary code
  // ************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      syndrome <= `EMSR_RST_CODE;
      primary  <= `EMSR_RST_CODE;
    end else if (capture) begin
      syndrome <= err_syndrome_i; // RULE_22
      primary  <= enc_primary;
    end else if (wr_status) begin
      syndrome <= reg_wdata_i[`EMSR_ST_SYN_HI:`EMSR_ST_SYN_LO];
      primary  <= reg_wdata_i[`EMSR_ST_PRI_HI:`EMSR_ST_PRI_LO];
    end
  end

  // ************************************
  // error data word and address
  // ************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      misc_data <= `EMSR_RST_WORD;
    end else if (capture) begin
      misc_data <= enc_data; // RULE_06
    end
  end

  // only the address-carrying syndromes fill it; others leave zero
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      paddr   <= '0;
      addr_ns <= 1'b0;
    end else if (capture) begin
      paddr   <= enc_addr_used ? err_paddr_i : '0; // RULE_17 RULE_18
      addr_ns <= enc_addr_used && err_ns_i;
    end
  end

  // ************************************
  // read path
  // ************************************
  always_comb begin
    misc_word = 64'h0;
    misc_word[31:0] = misc_data;
    misc_word[`EMSR_MISC_CNT_HI:`EMSR_MISC_CNT_LO] = count;
    misc_word[`EMSR_MISC_OVF] = cnt_ovf;
    misc_word[`EMSR_MISC_ROUND] = round_err;
    addr_word = 64'h0;
    addr_word[51:0] = paddr;
    addr_word[`EMSR_ADDR_NS] = addr_ns;
    status_word = 32'h0;
    status_word[`EMSR_ST_VALID]    = valid;
    status_word[`EMSR_ST_REC_OVF]  = rec_ovf;
    status_word[`EMSR_ST_MISC_VAL] = valid;
    status_word[`EMSR_ST_SYN_HI:`EMSR_ST_SYN_LO] = syndrome;
    status_word[`EMSR_ST_PRI_HI:`EMSR_ST_PRI_LO] = primary;
  end

  always_comb begin
    next_rdata = 32'h0;
    if (reg_addr_i == `EMSR_OFF_STATUS) begin
      next_rdata = status_word;
    end else if (reg_addr_i == `EMSR_OFF_MISC_LO) begin
      next_rdata = misc_word[31:0];
    end else if (reg_addr_i == `EMSR_OFF_MISC_HI) begin
      next_rdata = misc_word[63:32];
    end else if (reg_addr_i == `EMSR_OFF_ADDR_LO) begin
      next_rdata = addr_word[31:0];
    end else if (reg_addr_i == `EMSR_OFF_ADDR_HI) begin
      next_rdata = addr_word[63:32];
    end else if (reg_addr_i == `EMSR_OFF_CTRL) begin
      next_rdata = {31'h0, cf_irq_en};
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 32'h0;
    end else begin
      reg_rdata_o <= reg_rd_i ? next_rdata : 32'h0;
    end
  end

  // ************************************
  // checks
  // ************************************
  AST_OVF_STICKY: assert property ( // RULE_02
    @(posedge clk_i) disable iff (rst_i)
    cnt_ovf && !(wr_misc_hi && reg_wdata_i[8]) |=> cnt_ovf
  ) else $error("overflow flag dropped without a clear");

  AST_WRAP: assert property ( // RULE_23
    @(posedge clk_i) disable iff (rst_i)
    inc_any && !wr_misc_hi && count == 8'hFF |=> count == 8'h00 && cnt_ovf
  ) else $error("counter did not wrap with overflow");

  AST_INC: assert property ( // RULE_04
    @(posedge clk_i) disable iff (rst_i)
    inc_any && !wr_misc_hi |=> count == $past(count) + 8'h01
  ) else $error("counter missed an increment");

  AST_HOLD: assert property ( // RULE_05
    @(posedge clk_i) disable iff (rst_i)
    !inc_any && !wr_misc_hi |=> $stable(count)
  ) else $error("counter moved without a cause");

  AST_ROUND: assert property ( // RULE_01
    @(posedge clk_i) disable iff (rst_i)
    ce_i && inc_ue |=> round_err
  ) else $error("lost increment not flagged");

  AST_IRQ: assert property ( // RULE_03
    @(posedge clk_i) disable iff (rst_i)
    wrap && cf_irq_en && !wr_ctrl |-> ##2 fault_irq_o
  ) else $error("fault interrupt not raised on overflow");

  AST_SYNDROME: assert property ( // RULE_22
    @(posedge clk_i) disable iff (rst_i)
    capture |=> syndrome == $past(err_syndrome_i) && valid
  ) else $error("syndrome not captured");

  AST_PORT_PACK: assert property ( // RULE_08
    @(posedge clk_i) disable iff (rst_i)
    capture && err_syndrome_i == 8'h00 |=>
      misc_data == {19'h0, $past(err_rnw_i), $past(err_sparse_i),
                    $past(err_size_i), $past(err_len_i)}
  ) else $error("illegal access word mispacked");

  AST_CORE_PACK: assert property ( // RULE_09
    @(posedge clk_i) disable iff (rst_i)
    capture && err_syndrome_i == 8'h01 |=>
      misc_data == {7'h0, $past(err_unit_i), 7'h0, $past(err_core_i)}
          && primary == 8'h0F
  ) else $error("powered-down access word mispacked");

  AST_ADDR: assert property ( // RULE_17
    @(posedge clk_i) disable iff (rst_i)
    capture && err_syndrome_i == 8'h12 |=>
      paddr == $past(err_paddr_i) && misc_data == 32'h0 && primary == 8'h06
  ) else $error("corrupted read address not recorded");

  AST_ID_PACK: assert property ( // RULE_20
    @(posedge clk_i) disable iff (rst_i)
    capture && err_syndrome_i == 8'h19 |=>
      misc_data == {22'h0, $past(err_irq_id_i)}
  ) else $error("interrupt id mispacked");

  AST_MISC_READ: assert property ( // RULE_06
    @(posedge clk_i) disable iff (rst_i)
    reg_rd_i && reg_addr_i == `EMSR_OFF_MISC_LO |=>
      reg_rdata_o == $past(misc_data)
  ) else $error("data word read back wrong");

endmodule

// *** src/emsr_defines.svh ***
// register offsets, field positions, codes and reset values
`ifndef EMSR_DEFINES_SVH
`define EMSR_DEFINES_SVH

// ************************************
// register byte offsets
// ************************************
`define EMSR_OFF_STATUS  8'h00
`define EMSR_OFF_MISC_LO 8'h08
`define EMSR_OFF_MISC_HI 8'h0C
`define EMSR_OFF_ADDR_LO 8'h10
`define EMSR_OFF_ADDR_HI 8'h14
`define EMSR_OFF_CTRL    8'h18

// ************************************
// status register fields
// ************************************
`define EMSR_ST_VALID    30
`define EMSR_ST_REC_OVF  27
`define EMSR_ST_MISC_VAL 26
`define EMSR_ST_SYN_HI   15
`define EMSR_ST_SYN_LO   8
`define EMSR_ST_PRI_HI   7
`define EMSR_ST_PRI_LO   0

// ************************************
// miscellaneous and address register fields
// ************************************
`define EMSR_MISC_ROUND  41
`define EMSR_MISC_OVF    40
`define EMSR_MISC_CNT_HI 39
`define EMSR_MISC_CNT_LO 32
`define EMSR_ADDR_NS     63

// ************************************
// control register fields
// ************************************
`define EMSR_CTRL_CF_IRQ_EN 0

// ************************************
// reset values and counter maximum
// ************************************
`define EMSR_RST_COUNT 8'h00
`define EMSR_RST_CODE  8'h00
`define EMSR_RST_WORD  32'h0000_0000
`define EMSR_CNT_MAX   8'hFF

// ************************************
// syndrome codes
// ************************************
`define EMSR_SYN_ILLEGAL_PORT_ACCESS      8'h00
`define EMSR_SYN_UNIT_POWERED_DOWN_ACCESS 8'h01
`define EMSR_SYN_POWER_DOWN_REJECTED      8'h02
`define EMSR_SYN_PROPERTY_BASE_REJECTED   8'h04
`define EMSR_SYN_PENDING_BASE_REJECTED    8'h05
`define EMSR_SYN_WAKE_CHANGE_ABANDONED    8'h07
`define EMSR_SYN_SLEEP_REQUEST_FAILED     8'h08
`define EMSR_SYN_SLEEP_WITH_GROUPS_EN     8'h09
`define EMSR_SYN_SOFT_IRQ_NO_TARGET       8'h10
`define EMSR_SYN_SOFT_IRQ_CORRUPTED       8'h11
`define EMSR_SYN_PERCORE_SPACE_CORRUPTED  8'h12
`define EMSR_SYN_DIST_SPACE_CORRUPTED     8'h13
`define EMSR_SYN_TRANSLATOR_POWERED_OFF   8'h14
`define EMSR_SYN_SHARED_IRQ_BLOCK_MISSING 8'h18
`define EMSR_SYN_SHARED_IRQ_OUT_OF_RANGE  8'h19
`define EMSR_SYN_SHARED_IRQ_NO_TARGET     8'h1A

// ************************************
// primary error codes
// ************************************
`define EMSR_PRI_CORRUPT 8'h06
`define EMSR_PRI_ILLEGAL 8'h0E
`define EMSR_PRI_BADSTAT 8'h0F

`endif

// *** src/emsr_pkg.sv ***
// types shared by the error record bank
package emsr_pkg;
  typedef logic [7:0]  emsr_code_t;
  typedef logic [31:0] emsr_word_t;
  typedef logic [7:0]  emsr_addr_t;
  typedef logic [8:0]  emsr_core_t;
  typedef logic [51:0] emsr_paddr_t;
endpackage

// *** src/emsr_data_encoder.sv ***
// packs the error-information word and primary code for a syndrome
`timescale 1ns/100ps
`include "emsr_defines.svh"
module emsr_data_encoder (
  input  wire emsr_pkg::emsr_code_t syndrome_i,
  input  wire emsr_pkg::emsr_core_t core_i,
  input  wire emsr_pkg::emsr_core_t unit_i,
  input  wire logic                 rnw_i,
  input  wire logic                 sparse_i,
  input  wire logic [2:0]           size_i,
  input  wire logic [7:0]           len_i,
  input  wire logic [4:0]           block_i,
  input  wire logic [9:0]           irq_id_i,
  output emsr_pkg::emsr_word_t      data_o,
  output emsr_pkg::emsr_code_t      primary_o,
  output logic                      addr_used_o
);
  import emsr_pkg::*;

  always_comb begin
    data_o      = `EMSR_RST_WORD; // RULE_07
    primary_o   = `EMSR_PRI_BADSTAT;
    addr_used_o = 1'b0;
    case (syndrome_i)
      `EMSR_SYN_ILLEGAL_PORT_ACCESS: begin
        data_o      = {19'h0, rnw_i, sparse_i, size_i, len_i}; // RULE_08
        primary_o   = `EMSR_PRI_ILLEGAL;
        addr_used_o = 1'b1;
      end
      `EMSR_SYN_UNIT_POWERED_DOWN_ACCESS,
      `EMSR_SYN_POWER_DOWN_REJECTED: begin
        data_o = {7'h0, unit_i, 7'h0, core_i}; // RULE_09 RULE_10
      end
      `EMSR_SYN_PROPERTY_BASE_REJECTED,
      `EMSR_SYN_PENDING_BASE_REJECTED: begin
        data_o = {23'h0, core_i}; // RULE_11
      end
      `EMSR_SYN_WAKE_CHANGE_ABANDONED: begin
        data_o = {23'h0, core_i}; // RULE_12
      end
      `EMSR_SYN_SLEEP_REQUEST_FAILED: begin
        data_o = {23'h0, core_i}; // RULE_13
      end
      `EMSR_SYN_SLEEP_WITH_GROUPS_EN: begin
        data_o = {23'h0, core_i}; // RULE_14
      end
      `EMSR_SYN_SOFT_IRQ_NO_TARGET: begin
        data_o    = {23'h0, core_i}; // RULE_15
        primary_o = `EMSR_PRI_ILLEGAL;
      end
      `EMSR_SYN_SOFT_IRQ_CORRUPTED: begin
        data_o    = {23'h0, core_i}; // RULE_16
        primary_o = `EMSR_PRI_CORRUPT;
      end
      `EMSR_SYN_PERCORE_SPACE_CORRUPTED,
      `EMSR_SYN_DIST_SPACE_CORRUPTED: begin
        primary_o   = `EMSR_PRI_CORRUPT; // RULE_17
        addr_used_o = 1'b1;
      end
      `EMSR_SYN_TRANSLATOR_POWERED_OFF: begin
        addr_used_o = 1'b1; // RULE_18
      end
      `EMSR_SYN_SHARED_IRQ_BLOCK_MISSING: begin
        data_o    = {27'h0, block_i}; // RULE_19
        primary_o = `EMSR_PRI_ILLEGAL;
      end
      `EMSR_SYN_SHARED_IRQ_OUT_OF_RANGE: begin
        data_o    = {22'h0, irq_id_i}; // RULE_20
        primary_o = `EMSR_PRI_ILLEGAL;
      end
      `EMSR_SYN_SHARED_IRQ_NO_TARGET: begin
        data_o = {22'h0, irq_id_i}; // RULE_21
      end
      default: begin
        data_o = `EMSR_RST_WORD;
      end
    endcase
  end
endmodule

// *** tb/test_emsr_record.sv ***
// self-checking bench for software error record 0
`timescale 1ns/100ps
`include "emsr_defines.svh"
module test_emsr_record;
  import emsr_pkg::*;
  // ************************************
  // stimulus and observed signals
  // ************************************
  logic        clk_i          = 1'b0;
  logic        rst_i          = 1'b1;
  emsr_addr_t  reg_addr_i     = 8'h00;
  emsr_word_t  reg_wdata_i    = 32'h0000_0000;
  logic        reg_wr_i       = 1'b0;
  logic        reg_rd_i       = 1'b0;
  emsr_word_t  reg_rdata_o;
  logic        ce_i           = 1'b0;
  logic        err_valid_i    = 1'b0;
  emsr_code_t  err_syndrome_i = 8'h00;
  emsr_core_t  err_core_i     = 9'h1A5;
  emsr_core_t  err_unit_i     = 9'h0C3;
  logic        err_rnw_i      = 1'b1;
  logic        err_sparse_i   = 1'b0;
  logic [2:0]  err_size_i     = 3'h5;
  logic [7:0]  err_len_i      = 8'hA7;
  logic [4:0]  err_block_i    = 5'h13;
  logic [9:0]  err_irq_id_i   = 10'h2B6;
  emsr_paddr_t err_paddr_i    = 52'hABCDE_1234_5678;
  logic        err_ns_i       = 1'b1;
  logic        fault_irq_o;
  logic        record_valid_o;
  int          err_total      = 0;
  int          n_tests        = 0;
  emsr_word_t  v;
  emsr_code_t  s;
  emsr_code_t  syn_tab [16]   = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h05, 8'h07,
                                  8'h08, 8'h09, 8'h10, 8'h11, 8'h12, 8'h13,
                                  8'h14, 8'h18, 8'h19, 8'h1A};

  always #2.5 clk_i = ~clk_i;

  emsr_record emsr_record_i (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .reg_addr_i     (reg_addr_i),
    .reg_wdata_i    (reg_wdata_i),
    .reg_wr_i       (reg_wr_i),
    .reg_rd_i       (reg_rd_i),
    .reg_rdata_o    (reg_rdata_o),
    .ce_i           (ce_i),
    .err_valid_i    (err_valid_i),
    .err_syndrome_i (err_syndrome_i),
    .err_core_i     (err_core_i),
    .err_unit_i     (err_unit_i),
    .err_rnw_i      (err_rnw_i),
    .err_sparse_i   (err_sparse_i),
    .err_size_i     (err_size_i),
    .err_len_i      (err_len_i),
    .err_block_i    (err_block_i),
    .err_irq_id_i   (err_irq_id_i),
    .err_paddr_i    (err_paddr_i),
    .err_ns_i       (err_ns_i),
    .fault_irq_o    (fault_irq_o),
    .record_valid_o (record_valid_o)
  );

  // ************************************
  // bus, event and compare tasks
  // ************************************
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string n, input emsr_word_t e, input emsr_word_t g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input emsr_addr_t a, input emsr_word_t d);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
    reg_wr_i    <= 1'b0;
  endtask

  task automatic rd(input emsr_addr_t a, output emsr_word_t d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_i);
    reg_rd_i   <= 1'b0;
    #1 d = reg_rdata_o;
  endtask

  // one error event, optionally with a corrected error beside it
  task automatic ev(input emsr_code_t c, input logic corr);
    @(posedge clk_i);
    err_valid_i    <= 1'b1;
    err_syndrome_i <= c;
    ce_i           <= corr;
    @(posedge clk_i);
    err_valid_i    <= 1'b0;
    ce_i           <= 1'b0;
  endtask

  task automatic wait_fault(input logic lvl);
    int k;
    k = 0;
    while (fault_irq_o !== lvl && k < 8) begin
      @(posedge clk_i);
      #1 k++;
    end
    chk("fault_irq", {31'h0, lvl}, {31'h0, fault_irq_o});
    if (fault_irq_o !== lvl) begin
      end_of_test();
    end
  endtask

  function automatic emsr_word_t exp_word(input emsr_code_t c);
    case (c)
      8'h00: return {19'h0, err_rnw_i, err_sparse_i, err_size_i, err_len_i};
      8'h01, 8'h02: return {7'h0, err_unit_i, 7'h0, err_core_i};
      8'h04, 8'h05, 8'h07, 8'h08, 8'h09, 8'h10, 8'h11:
        return {23'h0, err_core_i};
      8'h18: return {27'h0, err_block_i};
      8'h19, 8'h1A: return {22'h0, err_irq_id_i};
      default: return 32'h0000_0000;
    endcase
  endfunction

  function automatic emsr_code_t exp_pri(input emsr_code_t c);
    case (c)
      8'h00, 8'h10, 8'h18, 8'h19: return 8'h0E;
      8'h11, 8'h12, 8'h13: return 8'h06;
      default: return 8'h0F;
    endcase
  endfunction

  function automatic logic addr_used(input emsr_code_t c);
    return c == 8'h00 || c == 8'h12 || c == 8'h13 || c == 8'h14;
  endfunction

  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    $display("FAIL watchdog expected finish seen hang");
    end_of_test();
  end

  // ************************************
  // main sequence
  // ************************************
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`EMSR_OFF_MISC_HI, v);
    chk("misc_hi_rst", 32'h0000_0000, v);
    chk("rec_valid_rst", 32'h0, {31'h0, record_valid_o});
    rd(8'h1C, v);
    chk("unmapped", 32'h0000_0000, v);
    $display("test reset done");

    for (int i = 0; i < 16; i++) begin
      s = syn_tab[i];
      wr(`EMSR_OFF_STATUS, 32'h4000_0000);
      ev(s, 1'b0);
      rd(`EMSR_OFF_STATUS, v);
      chk("status", {16'h4400, s, exp_pri(s)}, v);
      chk("rec_valid", 32'h1, {31'h0, record_valid_o});
      rd(`EMSR_OFF_MISC_LO, v);
      chk("data", exp_word(s), v);
      rd(`EMSR_OFF_ADDR_LO, v);
      chk("addr_lo", addr_used(s) ? err_paddr_i[31:0] : 32'h0, v);
      rd(`EMSR_OFF_ADDR_HI, v);
      chk("addr_hi", addr_used(s) ? {err_ns_i, 11'h0, err_paddr_i[51:32]}
          : 32'h0, v);
    end
    rd(`EMSR_OFF_STATUS, v);
    @(posedge clk_i);
    #1 chk("rdata_idle", 32'h0000_0000, reg_rdata_o);
    $display("test syndromes done");

    wr(`EMSR_OFF_MISC_HI, 32'h0000_00FE);
    wr(`EMSR_OFF_CTRL, 32'h0000_0001);
    ev(8'h1A, 1'b1);
    rd(`EMSR_OFF_MISC_HI, v);
    chk("count_ff", 32'h0000_00FF, v);
    chk("no_fault", 32'h0, {31'h0, fault_irq_o});
    @(posedge clk_i);
    ce_i <= 1'b1;
    @(posedge clk_i);
    ce_i <= 1'b0;
    rd(`EMSR_OFF_MISC_HI, v);
    chk("count_wrap", 32'h0000_0100, v);
    wait_fault(1'b1);
    ev(8'h1A, 1'b1);
    rd(`EMSR_OFF_MISC_HI, v);
    chk("ovf_sticky", 32'h0000_0101, v);
    rd(`EMSR_OFF_STATUS, v);
    chk("rec_ovf", 32'h4C00_1A0F, v);
    ev(8'h19, 1'b0);
    rd(`EMSR_OFF_MISC_HI, v);
    chk("count_diff", 32'h0000_0102, v);
    rd(`EMSR_OFF_MISC_LO, v);
    chk("data_held", exp_word(8'h1A), v);
    $display("test counter done");

    ev(8'h01, 1'b1);
    rd(`EMSR_OFF_MISC_HI, v);
    chk("rounding", 32'h1, {31'h0, v[9]});
    wr(`EMSR_OFF_MISC_HI, 32'h0000_0300);
    rd(`EMSR_OFF_MISC_HI, v);
    chk("flags_clr", 32'h0000_0000, v);
    wait_fault(1'b0);
    wr(`EMSR_OFF_STATUS, 32'h4800_0000);
    rd(`EMSR_OFF_STATUS, v);
    chk("status_clr", 32'h0000_0000, v);
    chk("rec_valid_clr", 32'h0, {31'h0, record_valid_o});
    ev(8'h03, 1'b0);
    rd(`EMSR_OFF_STATUS, v);
    chk("status_unk", 32'h4400_030F, v);
    rd(`EMSR_OFF_MISC_LO, v);
    chk("data_unk", 32'h0000_0000, v);
    $display("test flags done");
    end_of_test();
  end
endmodule
